// [hdl/ebr_bus_seq.sv]
// External bus cycle sequencer with release/regain arbitration
`timescale 1ns/10ps
`default_nettype none
module ebr_bus_seq #(
  parameter int unsigned AW = 16,
  parameter int unsigned DW = 16
) (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_reset,
  // Register port
  input  wire logic [7:0]    i_reg_addr,
  input  wire logic [31:0]   i_reg_wdata,
  input  wire logic          i_reg_wr,
  input  wire logic          i_reg_rd,
  output logic [31:0]        o_reg_rdata,
  // Access requests
  input  wire logic          i_req_valid,
  input  wire logic          i_req_write,
  input  wire logic [AW-1:0] i_req_addr,
  input  wire logic [DW-1:0] i_req_wdata,
  output logic               o_req_ready,
  // Read results
  output logic               o_rd_valid,
  output logic [DW-1:0]      o_rd_data,
  // External bus pins
  output logic               o_ale,
  output logic               o_read_strobe_n,
  output logic               o_store_strobe_n,
  output logic               o_chip_select_n,
  output logic               o_chip_select_n_oe,
  output logic [AW-1:0]      o_addr,
  output logic               o_addr_oe,
  output logic [DW-1:0]      o_ad_out,
  output logic               o_ad_oe,
  input  wire logic [DW-1:0] i_ad_in,
  input  wire logic          i_ready_n,
  output logic               o_sys_clock_output,
  // Arbitration pins
  input  wire logic          i_bus_release_request_n,
  output logic               o_release_ack_n,
  output logic               o_regain_request_n,
  // Clock source strap
  input  wire logic          i_clk_src_strap,
  output logic               o_pll_enabled
);
  localparam int unsigned PW = 1 + AW + DW;

  ebr_pkg::ebr_state_t state_q, state_d;
  logic [5:0]    cnt_q, cnt_d;
  logic [7:0]    cfg_q, cfg_d, snap_q, snap_d;
  logic [PW-1:0] req_q, req_d;
  logic [31:0]   rdata_d;
  logic [7:0]    ncyc_q, ncyc_d;
  logic          strap_done_q, strap_done_d, pll_d;
  logic          buf_valid, buf_pop;
  logic [PW-1:0] buf_data;
  logic [5:0]    addr_len, cmd_len, gap_len;
  logic          s_mux, s_cdly, s_tri, s_rdy, r_wr;
  // Registered pin values
  logic          ale_d, rds_d, sts_d, cs_d, drv_d, aoe_d, ack_d, brq_d, rdv_d;
  logic [AW-1:0] addr_d;
  logic [DW-1:0] ad_d, rdd_d;

  ebr_buf2 #(.W(PW)) ebr_buf2_i (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_in_valid  (i_req_valid),
    .i_in_data   ({i_req_write, i_req_addr, i_req_wdata}),
    .o_in_ready  (o_req_ready),
    .o_out_valid (buf_valid),
    .o_out_data  (buf_data),
    .i_out_ready (buf_pop)
  );

  // Cycle shape from the per-cycle settings snapshot
  always_comb begin
    s_mux    = snap_q[ebr_pkg::CFG_MUX_BIT];
    s_cdly   = snap_q[ebr_pkg::CFG_CDLY_BIT];
    s_tri    = snap_q[ebr_pkg::CFG_TRI_BIT];
    s_rdy    = snap_q[ebr_pkg::CFG_RDY_BIT];
    r_wr     = req_q[PW-1];
    addr_len = (s_mux ? ebr_pkg::MUX_ADDR_TCL : ebr_pkg::DEMUX_ADDR_TCL)
             + (s_cdly ? ebr_pkg::CMD_DELAY_TCL : 6'h00);
    cmd_len  = (s_mux ? ebr_pkg::MUX_CMD_TCL : ebr_pkg::DEMUX_CMD_TCL)
             + {1'b0, snap_q[ebr_pkg::CFG_WAIT_LSB +: ebr_pkg::CFG_WAIT_W], 1'b0};
    gap_len  = (s_mux ? ebr_pkg::ADDR_GAP_TCL : 6'h00)
             + (s_tri ? ebr_pkg::TRI_WAIT_TCL : 6'h00);
  end

  // Sequencer: one core clock cycle is one half_clock_period
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 6'h01;
    snap_d  = snap_q;
    req_d   = req_q;
    ncyc_d  = ncyc_q;
    buf_pop = 1'b0;
    case (state_q)
      ebr_pkg::ST_IDLE: begin
        cnt_d = 6'h00;
        if (!i_bus_release_request_n) begin
          state_d = ebr_pkg::ST_FLOAT;
        end else if (buf_valid) begin
          buf_pop = 1'b1;
          req_d   = buf_data;
          snap_d  = cfg_q;
          ncyc_d  = ncyc_q + 8'h01;
          state_d = ebr_pkg::ST_ADDR;
        end
      end
      ebr_pkg::ST_ADDR: begin
        if (cnt_q == addr_len - 6'h01) begin
          cnt_d   = 6'h00;
          state_d = ebr_pkg::ST_CMD;
        end
      end
      ebr_pkg::ST_CMD: begin
        if (cnt_q == cmd_len - 6'h01) begin
          cnt_d   = 6'h00;
          state_d = s_rdy ? ebr_pkg::ST_RDY : ebr_pkg::ST_END;
        end
      end
      ebr_pkg::ST_RDY: begin
        // Sampled as synchronous; partner keeps it until the strobe rises
        if (!i_ready_n) begin
          state_d = ebr_pkg::ST_END;
        end
      end
      ebr_pkg::ST_END: begin
        cnt_d   = 6'h00;
        state_d = (gap_len != 6'h00) ? ebr_pkg::ST_GAP : ebr_pkg::ST_IDLE;
      end
      ebr_pkg::ST_GAP: begin
        if (cnt_q == gap_len - 6'h01) begin
          state_d = ebr_pkg::ST_IDLE;
        end
      end
      ebr_pkg::ST_FLOAT: begin
        state_d = ebr_pkg::ST_RELEASED;
      end
      ebr_pkg::ST_RELEASED: begin
        if (i_bus_release_request_n) begin
          state_d = ebr_pkg::ST_REGAIN;
        end
      end
      ebr_pkg::ST_REGAIN: begin
        state_d = ebr_pkg::ST_IDLE;
      end
      default: begin
        state_d = ebr_pkg::ST_IDLE;
      end
    endcase
  end

  // Pin values follow the next state so every pin is a flip-flop
  always_comb begin
    ale_d  = (state_d == ebr_pkg::ST_ADDR) && (cnt_d == 6'h00);
    rds_d  = !(((state_d == ebr_pkg::ST_CMD) || (state_d == ebr_pkg::ST_RDY)) && !req_d[PW-1]);
    sts_d  = !(((state_d == ebr_pkg::ST_CMD) || (state_d == ebr_pkg::ST_RDY)) && req_d[PW-1]);
    cs_d   = !((state_d == ebr_pkg::ST_ADDR) || (state_d == ebr_pkg::ST_CMD)
            || (state_d == ebr_pkg::ST_RDY) || (state_d == ebr_pkg::ST_END));
    drv_d  = !((state_d == ebr_pkg::ST_FLOAT) || (state_d == ebr_pkg::ST_RELEASED)
            || (state_d == ebr_pkg::ST_REGAIN));
    addr_d = req_d[DW +: AW];
    aoe_d  = drv_d && (((state_d == ebr_pkg::ST_ADDR) && snap_d[ebr_pkg::CFG_MUX_BIT])
            || (req_d[PW-1] && ((state_d == ebr_pkg::ST_CMD) || (state_d == ebr_pkg::ST_RDY)
            || (state_d == ebr_pkg::ST_END))));
    ad_d   = ((state_d == ebr_pkg::ST_ADDR) && snap_d[ebr_pkg::CFG_MUX_BIT])
            ? DW'(req_d[DW +: AW]) : req_d[DW-1:0];
    ack_d  = (state_d != ebr_pkg::ST_RELEASED);
    brq_d  = !((state_d == ebr_pkg::ST_RELEASED) && buf_valid);
    rdv_d  = (state_d == ebr_pkg::ST_END) && (state_q != ebr_pkg::ST_END) && !req_q[PW-1];
    rdd_d  = rdv_d ? i_ad_in : o_rd_data;
  end

  // Register port and strap capture after reset release
  always_comb begin
    cfg_d = cfg_q;
    if (i_reg_wr && (i_reg_addr == ebr_pkg::REG_CFG_OFS)) begin
      cfg_d = i_reg_wdata[ebr_pkg::CFG_W-1:0];
    end
    rdata_d = 32'h0000_0000;
    if (i_reg_rd) begin
      case (i_reg_addr)
        ebr_pkg::REG_CFG_OFS:  rdata_d = {24'h00_0000, cfg_q};
        ebr_pkg::REG_STAT_OFS: rdata_d = {16'h0000, ncyc_q, 3'h0, buf_valid,
                                          o_pll_enabled, !o_release_ack_n,
                                          !o_regain_request_n,
                                          state_q != ebr_pkg::ST_IDLE};
        default:               rdata_d = 32'h0000_0000;
      endcase
    end
    strap_done_d = 1'b1;
    pll_d        = strap_done_q ? o_pll_enabled : i_clk_src_strap;
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q            <= ebr_pkg::ST_IDLE;
      cnt_q              <= 6'h00;
      cfg_q              <= ebr_pkg::CFG_RESET;
      snap_q             <= ebr_pkg::CFG_RESET;
      req_q              <= '0;
      ncyc_q             <= 8'h00;
      strap_done_q       <= 1'b0;
      o_pll_enabled      <= 1'b0;
      o_reg_rdata        <= 32'h0000_0000;
      o_ale              <= 1'b0;
      o_read_strobe_n    <= 1'b1;
      o_store_strobe_n   <= 1'b1;
      o_chip_select_n    <= 1'b1;
      o_chip_select_n_oe <= 1'b1;
      o_addr             <= '0;
      o_addr_oe          <= 1'b1;
      o_ad_out           <= '0;
      o_ad_oe            <= 1'b0;
      o_release_ack_n    <= 1'b1;
      o_regain_request_n <= 1'b1;
      o_rd_valid         <= 1'b0;
      o_rd_data          <= '0;
      o_sys_clock_output <= 1'b0;
    end else begin
      state_q            <= state_d;
      cnt_q              <= cnt_d;
      cfg_q              <= cfg_d;
      snap_q             <= snap_d;
      req_q              <= req_d;
      ncyc_q             <= ncyc_d;
      strap_done_q       <= strap_done_d;
      o_pll_enabled      <= pll_d;
      o_reg_rdata        <= rdata_d;
      o_ale              <= ale_d;
      o_read_strobe_n    <= rds_d;
      o_store_strobe_n   <= sts_d;
      o_chip_select_n    <= cs_d;
      o_chip_select_n_oe <= drv_d;
      o_addr             <= addr_d;
      o_addr_oe          <= drv_d;
      o_ad_out           <= ad_d;
      o_ad_oe            <= aoe_d;
      o_release_ack_n    <= ack_d;
      o_regain_request_n <= brq_d;
      o_rd_valid         <= rdv_d;
      o_rd_data          <= rdd_d;
      o_sys_clock_output <= ~o_sys_clock_output;
    end
  end

  // Checking helpers: cycle length and strobe offset from the strobe of ALE
  logic [7:0] len_q, waits_q, exp_len, since_ale_q;
  logic       cmd_on;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      len_q       <= 8'h00;
      waits_q     <= 8'h00;
      since_ale_q <= 8'h00;
    end else begin
      len_q       <= (state_q == ebr_pkg::ST_IDLE) ? 8'h00 : len_q + 8'h01;
      waits_q     <= (state_q == ebr_pkg::ST_IDLE) ? 8'h00
                   : waits_q + {7'h00, state_q == ebr_pkg::ST_RDY};
      since_ale_q <= o_ale ? 8'h01 : since_ale_q + 8'h01;
    end
  end
  always_comb begin
    cmd_on  = !(o_read_strobe_n && o_store_strobe_n);
    exp_len = {2'h0, addr_len} + {2'h0, cmd_len} + {2'h0, ebr_pkg::END_TCL}
            + {2'h0, gap_len} + waits_q;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  a_mux_cycle_len: assert property (
    s_mux && (state_q == ebr_pkg::ST_END || state_q == ebr_pkg::ST_GAP)
    && state_d == ebr_pkg::ST_IDLE
    |-> len_q + 8'h01 == exp_len && exp_len >= 8'h06)
    else $error("multiplexed cycle length wrong");
  a_demux_cycle_len: assert property (
    !s_mux && (state_q == ebr_pkg::ST_END || state_q == ebr_pkg::ST_GAP)
    && state_d == ebr_pkg::ST_IDLE
    |-> len_q + 8'h01 == exp_len && exp_len >= 8'h04)
    else $error("demultiplexed cycle length wrong");
  a_cmd_delay_pos: assert property (
    $rose(cmd_on) |-> since_ale_q == {2'h0, addr_len})
    else $error("strobe leading edge misplaced");
  a_ready_wait: assert property (
    state_q == ebr_pkg::ST_RDY && i_ready_n |=> state_q == ebr_pkg::ST_RDY && cmd_on)
    else $error("ready high did not add a wait state");
  a_ready_end: assert property (
    state_q == ebr_pkg::ST_RDY && !i_ready_n |=> !cmd_on ##1 !o_chip_select_n_oe || o_chip_select_n)
    else $error("ready low did not end the cycle");
  a_mux_tri_gap: assert property (
    state_q == ebr_pkg::ST_END && s_mux && s_tri
    |=> (state_q == ebr_pkg::ST_GAP)[*4] ##1 state_q != ebr_pkg::ST_GAP)
    else $error("multiplexed tristate gap not two output clocks");
  a_demux_no_gap: assert property (
    state_q == ebr_pkg::ST_END && !s_mux && !s_tri |=> state_q == ebr_pkg::ST_IDLE)
    else $error("demultiplexed gap not zero");
  a_release_after_cycle: assert property (
    state_q == ebr_pkg::ST_FLOAT |-> $past(state_q) == ebr_pkg::ST_IDLE && o_chip_select_n)
    else $error("bus released inside a cycle");
  a_cs_floated: assert property (
    !o_release_ack_n |-> !o_chip_select_n_oe && !o_addr_oe && !o_ad_oe)
    else $error("chip select driven while released");
  a_regain_hold: assert property (
    state_q == ebr_pkg::ST_RELEASED && !i_bus_release_request_n
    |=> !o_release_ack_n)
    else $error("regain started while request still low");
  a_regain_order: assert property (
    $rose(o_release_ack_n) |-> !o_chip_select_n_oe && !o_ale ##1 o_chip_select_n_oe && !o_ale)
    else $error("bus driven before regain completed");
  a_ack_after_float: assert property (
    $fell(o_release_ack_n) |-> $past(!o_chip_select_n_oe))
    else $error("acknowledge before float");
  a_regain_request_n_scope: assert property (
    !o_regain_request_n |-> !o_release_ack_n)
    else $error("regain request outside release");
  a_clk_out_tgl: assert property (
    !$past(i_reset) |-> o_sys_clock_output != $past(o_sys_clock_output))
    else $error("clock output did not toggle");

  c_mux_cycle: cover property (state_q == ebr_pkg::ST_GAP && s_mux && s_tri);
  c_ready_wait: cover property (state_q == ebr_pkg::ST_RDY ##1 state_q == ebr_pkg::ST_RDY);
  c_release: cover property ($fell(o_release_ack_n));
  c_regain_req: cover property (!o_regain_request_n ##[1:20] o_release_ack_n);
endmodule : ebr_bus_seq
`default_nettype wire

// [hdl/ebr_pkg.sv]
// Shared constants for the external bus sequencer
package ebr_pkg;
  // Core clock
  localparam int unsigned CLK_PERIOD_NS  = 10;
  // Register map, byte addresses
  localparam logic [7:0]  REG_CFG_OFS    = 8'h00;
  localparam logic [7:0]  REG_STAT_OFS   = 8'h04;
  // Configuration field positions
  localparam int unsigned CFG_MUX_BIT    = 0;
  localparam int unsigned CFG_WAIT_LSB   = 1;
  localparam int unsigned CFG_WAIT_W     = 4;
  localparam int unsigned CFG_CDLY_BIT   = 5;
  localparam int unsigned CFG_TRI_BIT    = 6;
  localparam int unsigned CFG_RDY_BIT    = 7;
  localparam int unsigned CFG_W          = 8;
  localparam logic [7:0]  CFG_RESET      = 8'h01;
  // Cycle shape in half_clock_period units
  localparam logic [5:0]  MUX_ADDR_TCL   = 6'h02;
  localparam logic [5:0]  DEMUX_ADDR_TCL = 6'h01;
  localparam logic [5:0]  MUX_CMD_TCL    = 6'h03;
  localparam logic [5:0]  DEMUX_CMD_TCL  = 6'h02;
  localparam logic [5:0]  END_TCL        = 6'h01;
  localparam logic [5:0]  CMD_DELAY_TCL  = 6'h02;
  localparam logic [5:0]  ADDR_GAP_TCL   = 6'h02;
  localparam logic [5:0]  TRI_WAIT_TCL   = 6'h02;
  // Clock source strap
  localparam int unsigned PLL_MULT       = 4;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_RDY, ST_END, ST_GAP, ST_FLOAT, ST_RELEASED, ST_REGAIN
  } ebr_state_t;
endpackage : ebr_pkg

// [hdl/ebr_buf2.sv]
// Two-entry request buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module ebr_buf2 #(
  parameter int unsigned W = 33
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_reset,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic         wp_q, wp_d, rp_q, rp_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         push, pop;

  always_comb begin
    push   = i_in_valid && (cnt_q != 2'h2);
    pop    = i_out_ready && (cnt_q != 2'h0);
    mem_d  = mem_q;
    wp_d   = wp_q;
    rp_d   = rp_q;
    cnt_d  = cnt_q;
    if (push) begin
      mem_d[wp_q] = i_in_data;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_in_ready  = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_data  = mem_q[rp_q];

  a_buf_no_over: assert property (@(posedge i_core_clk) disable iff (i_reset)
    cnt_q == 2'h2 && !pop |=> cnt_q == 2'h2)
    else $error("buffer lost a word while full");
endmodule : ebr_buf2
`default_nettype wire

// [tb/ebr_ext_mem.sv]
// Behavioural external memory with a programmable READY delay
`timescale 1ns/10ps
`default_nettype none
module ebr_ext_mem (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // Bench controls
  input  wire logic        i_muxed,
  input  wire logic [5:0]  i_ready_dly,
  // Bus from the sequencer
  input  wire logic        i_ale,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_store_strobe_n,
  input  wire logic        i_chip_select_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_ad_out,
  // Answer to the sequencer
  output logic [15:0]      o_ad_in,
  output logic             o_ready_n
);
  logic [15:0] mem_q [16];
  logic [3:0]  addr_q;
  logic [15:0] last_q;
  logic [5:0]  cnt_q;
  logic        cmd;
  assign cmd = !i_read_strobe_n || !i_store_strobe_n;
  // Data only while the read strobe is low, else a pattern changing every cycle
  assign o_ad_in = (!i_read_strobe_n && !i_chip_select_n) ? mem_q[addr_q] : ~last_q;
  // READY low after the delay, withdrawn as soon as the command ends
  assign o_ready_n = !(cmd && cnt_q >= i_ready_dly);
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      addr_q <= 4'h0;
      last_q <= 16'h0;
      cnt_q  <= 6'h0;
    end else begin
      last_q <= o_ad_in;
      cnt_q  <= cmd ? cnt_q + 6'h1 : 6'h0;
      if (i_ale) addr_q <= i_muxed ? i_ad_out[3:0] : i_addr[3:0];
      if (!i_store_strobe_n && !i_chip_select_n) mem_q[addr_q] <= i_ad_out;
    end
  end
endmodule : ebr_ext_mem
`default_nettype wire

// [tb/tb_ebr_bus_seq.sv]
// Self-checking bench for the external bus sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_ebr_bus_seq;
  logic        clk, rst, r_wr, r_rd, q_val, q_wr, q_rdy, rdy_n, hold_n, ok, muxed;
  logic        rd_val, ale, rs_n, ws_n, cs_n, cs_oe, addr_oe, ad_oe, clko, ack_n, regain_n, pll;
  logic        cs_p, st_p, ck_p, run;
  logic [5:0]  dly;
  logic [7:0]  r_addr;
  logic [31:0] r_wdata, r_rdata;
  logic [15:0] q_addr, q_wdata, ad_in, rd_data, addr, ad_out, rd_last;
  int          err_count, checked, cyc, ncyc, cs_cnt, last_len, prev_len, ale_t, end_t, gap, off;
  wire         cs_w = cs_oe ? cs_n : 1'h1;

  ebr_bus_seq ebr_bus_seq_i (
    .i_core_clk(clk), .i_reset(rst), .i_reg_addr(r_addr), .i_reg_wdata(r_wdata),
    .i_reg_wr(r_wr), .i_reg_rd(r_rd), .o_reg_rdata(r_rdata), .i_req_valid(q_val),
    .i_req_write(q_wr), .i_req_addr(q_addr), .i_req_wdata(q_wdata), .o_req_ready(q_rdy),
    .o_rd_valid(rd_val), .o_rd_data(rd_data), .o_ale(ale), .o_read_strobe_n(rs_n),
    .o_store_strobe_n(ws_n), .o_chip_select_n(cs_n), .o_chip_select_n_oe(cs_oe),
    .o_addr(addr), .o_addr_oe(addr_oe), .o_ad_out(ad_out), .o_ad_oe(ad_oe), .i_ad_in(ad_in),
    .i_ready_n(rdy_n), .o_sys_clock_output(clko), .i_bus_release_request_n(hold_n),
    .o_release_ack_n(ack_n), .o_regain_request_n(regain_n), .i_clk_src_strap(1'h1),
    .o_pll_enabled(pll));
  ebr_ext_mem ebr_ext_mem_i (
    .i_core_clk(clk), .i_reset(rst), .i_muxed(muxed), .i_ready_dly(dly), .i_ale(ale),
    .i_read_strobe_n(rs_n), .i_store_strobe_n(ws_n), .i_chip_select_n(cs_w),
    .i_addr(addr), .i_ad_out(ad_out), .o_ad_in(ad_in), .o_ready_n(rdy_n));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("errors %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Bus-cycle monitor: lengths, strobe offset, gaps and pin-level relations
  always @(posedge clk) begin
    cyc    <= cyc + 1;
    cs_p   <= cs_w;
    st_p   <= rs_n & ws_n;
    ck_p   <= clko;
    run    <= !rst;
    cs_cnt <= (cs_w === 1'h0) ? cs_cnt + 1 : 0;
    if (ale === 1'h1) begin
      ale_t <= cyc;
      gap   <= cyc - end_t;
      check(ack_n && cs_oe, 1'h1);
    end
    if (cs_w === 1'h1 && cs_p === 1'h0) begin
      ncyc     <= ncyc + 1;
      prev_len <= last_len;
      last_len <= cs_cnt;
      end_t    <= cyc;
    end
    if ((rs_n & ws_n) === 1'h0 && st_p === 1'h1) off <= cyc - ale_t;
    if (rd_val === 1'h1) rd_last <= rd_data;
    if (run) check(clko, !ck_p);
    if (ack_n === 1'h0) check({cs_oe, addr_oe, ad_oe}, 3'h0);
    if (regain_n === 1'h0) check(ack_n, 1'h0);
  end

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    r_wr    <= 1'h1;
    r_addr  <= a;
    r_wdata <= d;
    @(posedge clk);
    r_wr <= 1'h0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    r_rd   <= 1'h1;
    r_addr <= a;
    @(posedge clk);
    r_rd <= 1'h0;
    #1 d = r_rdata;
  endtask : reg_rd

  // Offer one request; give up after lim extra edges without ready
  task automatic push(input logic w, input logic [15:0] a, input logic [15:0] d, input int lim);
    int n;
    n = 0;
    @(posedge clk);
    q_val   <= 1'h1;
    q_wr    <= w;
    q_addr  <= a;
    q_wdata <= d;
    @(posedge clk);
    while (q_rdy !== 1'h1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    ok = q_rdy;
    q_val <= 1'h0;
  endtask : push

  task automatic wait_cyc(input int k);
    int n;
    n = 0;
    while (ncyc < k && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_cyc

  task automatic wait_ack(input logic v);
    int n;
    n = 0;
    while (ack_n !== v && n < 40) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_ack

  task automatic measure(input logic [7:0] c, input logic [5:0] d, output int len, output int o);
    reg_wr(ebr_pkg::REG_CFG_OFS, {24'h0, c});
    muxed <= c[0];
    dly   <= d;
    push(1'h0, 16'h0003, 16'h0, 50);
    wait_cyc(ncyc + 1);
    len = last_len;
    o = off;
  endtask : measure

  task automatic t_regs;
    logic [31:0] d;
    reg_rd(ebr_pkg::REG_CFG_OFS, d);
    check(d, {24'h0, ebr_pkg::CFG_RESET});
    reg_wr(ebr_pkg::REG_CFG_OFS, 32'h0000_01a5);
    reg_rd(ebr_pkg::REG_CFG_OFS, d);
    check(d, 32'h0000_00a5);
    reg_rd(8'h08, d);
    check(d, 32'h0);
    reg_rd(ebr_pkg::REG_STAT_OFS, d);
    check(d[3], 1'h1);
    check(pll, 1'h1);
  endtask : t_regs

  task automatic t_len;
    int len, o, w;
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 2; c++) begin
        for (int k = 0; k < 3; k++) begin
          w = (k == 0) ? 0 : (k == 1) ? 1 : 15;
          measure({2'h0, c[0], w[3:0], m[0]}, 6'h0, len, o);
          check(len, (m ? 6 : 4) + 2 * c + 2 * w);
          check(o, (m ? 2 : 1) + 2 * c);
        end
      end
    end
  endtask : t_len

  task automatic t_ready;
    int l0, l1, l2, o;
    measure(8'h80, 6'h00, l0, o);
    check(l0, 5);
    measure(8'h80, 6'h0a, l1, o);
    check(l1 > 4, 1'h1);
    measure(8'h80, 6'h0d, l2, o);
    check(l2 - l1, 3);
  endtask : t_ready

  task automatic t_gap;
    int g0;
    g0 = 0;
    dly <= 6'h0;
    for (int k = 0; k < 4; k++) begin
      reg_wr(ebr_pkg::REG_CFG_OFS, {25'h0, k[1], 5'h0, k[0]});
      muxed <= k[0];
      push(1'h0, 16'h0001, 16'h0, 50);
      push(1'h0, 16'h0002, 16'h0, 50);
      wait_cyc(ncyc + 2);
      if (k == 0) g0 = gap;
      check(gap - g0, 2 * k[0] + 2 * k[1]);
    end
  endtask : t_gap

  task automatic t_next;
    int n;
    n = 0;
    reg_wr(ebr_pkg::REG_CFG_OFS, 32'h0);
    muxed <= 1'h0;
    push(1'h0, 16'h0001, 16'h0, 50);
    push(1'h0, 16'h0002, 16'h0, 50);
    while (ale !== 1'h1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    reg_wr(ebr_pkg::REG_CFG_OFS, 32'h06);
    wait_cyc(ncyc + 2);
    check(prev_len, 4);
    check(last_len, 10);
  endtask : t_next

  task automatic t_arb;
    int c1;
    reg_wr(ebr_pkg::REG_CFG_OFS, 32'h0);
    push(1'h1, 16'h0005, 16'h1234, 50);
    push(1'h0, 16'h0005, 16'h0, 50);
    c1 = ncyc + 2;
    wait_cyc(ncyc + 1);
    while (ale !== 1'h1 && ncyc < c1) @(posedge clk);
    hold_n <= 1'h0;
    wait_ack(1'h0);
    check(ncyc, c1);
    check(last_len, 4);
    check(rd_last, 16'h1234);
    push(1'h0, 16'h0005, 16'h0, 50);
    push(1'h0, 16'h0005, 16'h0, 50);
    push(1'h0, 16'h0007, 16'h0, 3);
    check(ok, 1'h0);
    repeat (20) @(posedge clk);
    check(ncyc, c1);
    check(regain_n, 1'h0);
    check(ack_n, 1'h0);
    reg_wr(ebr_pkg::REG_CFG_OFS, 32'h80);
    dly <= 6'h08;
    rd_last <= 16'h0;
    hold_n <= 1'h1;
    wait_ack(1'h1);
    check(ack_n, 1'h1);
    wait_cyc(c1 + 2);
    check(ncyc, c1 + 2);
    check(rd_last, 16'h1234);
    hold_n <= 1'h0;
    wait_ack(1'h0);
    check(regain_n, 1'h1);
    hold_n <= 1'h1;
    wait_ack(1'h1);
    check(ack_n, 1'h1);
  endtask : t_arb

  initial begin
    {rst, cs_p, st_p, hold_n} = 4'hf;
    {r_wr, r_rd, q_val, q_wr, ok, muxed, ck_p, run} = 8'h0;
    {r_addr, r_wdata, q_addr, q_wdata, dly, rd_last} = 94'h0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    t_regs;
    t_len;
    t_ready;
    t_gap;
    t_next;
    t_arb;
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run;
  end
endmodule : tb_ebr_bus_seq
`default_nettype wire
